// File: logic/mbr_pkg.sv
package mbr_pkg;

  // --------------------------------------------------------------------
  // Sizes
  // --------------------------------------------------------------------
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned PHYS_REGS = 31;
  localparam int unsigned PHYS_W    = 5;
  localparam int unsigned ARCH_W    = 4;
  localparam int unsigned SAVED_CNT = 5;

  // --------------------------------------------------------------------
  // Architectural register indices
  // --------------------------------------------------------------------
  localparam logic [3:0] IDX_LAST_SHARED = 4'h7;
  localparam logic [3:0] IDX_FIRST_BANK  = 4'h8;
  localparam logic [3:0] IDX_LAST_FAST   = 4'hc;
  localparam logic [3:0] IDX_STACK_PTR   = 4'hd;
  localparam logic [3:0] IDX_LINK        = 4'he;
  localparam logic [3:0] IDX_PROG_CNT    = 4'hf;

  // --------------------------------------------------------------------
  // Physical slots of the banked copies
  // --------------------------------------------------------------------
  localparam logic [4:0] PHYS_FAST_BASE = 5'h10;
  localparam logic [4:0] PHYS_FAST_SP   = 5'h15;
  localparam logic [4:0] PHYS_NIRQ_SP   = 5'h17;
  localparam logic [4:0] PHYS_SUPV_SP   = 5'h19;
  localparam logic [4:0] PHYS_ABRT_SP   = 5'h1b;
  localparam logic [4:0] PHYS_UNDF_SP   = 5'h1d;

  // --------------------------------------------------------------------
  // Mode codes and status word layout
  // --------------------------------------------------------------------
  localparam logic [4:0] MODE_USER = 5'h10;
  localparam logic [4:0] MODE_FAST = 5'h11;
  localparam logic [4:0] MODE_NIRQ = 5'h12;
  localparam logic [4:0] MODE_SUPV = 5'h13;
  localparam logic [4:0] MODE_ABRT = 5'h17;
  localparam logic [4:0] MODE_UNDF = 5'h1b;
  localparam logic [4:0] MODE_SYST = 5'h1f;

  localparam int unsigned MODE_LSB  = 0;
  localparam int unsigned CTRL_MSB  = 7;
  localparam int unsigned FLAGS_LSB = 28;
  localparam logic [31:0] STATUS_RESET = 32'h0000_00d3;

  // --------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------
  typedef struct packed {
    logic       en;
    logic [3:0] idx;
  } mbr_rd_req_t;

  typedef struct packed {
    logic        en;
    logic [3:0]  idx;
    logic [31:0] data;
  } mbr_wr_req_t;

  typedef struct packed {
    logic        en;
    logic [4:0]  mode;
    logic [31:0] ret_addr;
  } mbr_exc_req_t;

  typedef struct packed {
    logic        en;
    logic [31:0] data;
  } mbr_status_wr_t;

  // --------------------------------------------------------------------
  // Bank mapping
  // --------------------------------------------------------------------
  function automatic logic [4:0] mbr_phys(input logic [4:0] mode, input logic [3:0] idx);
    logic [4:0] base;
    base = 5'h0;
    if (idx <= IDX_LAST_SHARED || idx == IDX_PROG_CNT)
      return {1'b0, idx};
    if (mode == MODE_FAST && idx <= IDX_LAST_FAST)
      return PHYS_FAST_BASE + 5'({1'b0, idx - IDX_FIRST_BANK});
    if (idx <= IDX_LAST_FAST)
      return {1'b0, idx};
    case (mode)
      MODE_FAST: base = PHYS_FAST_SP;
      MODE_NIRQ: base = PHYS_NIRQ_SP;
      MODE_SUPV: base = PHYS_SUPV_SP;
      MODE_ABRT: base = PHYS_ABRT_SP;
      MODE_UNDF: base = PHYS_UNDF_SP;
      default:   base = {1'b0, IDX_STACK_PTR};
    endcase
    return base + 5'(idx == IDX_LINK);
  endfunction

  // Slot of the saved status word; the top bit flags that the mode has one.
  function automatic logic [3:0] mbr_saved_sel(input logic [4:0] mode);
    case (mode)
      MODE_FAST: return 4'h8;
      MODE_NIRQ: return 4'h9;
      MODE_SUPV: return 4'ha;
      MODE_ABRT: return 4'hb;
      MODE_UNDF: return 4'hc;
      default:   return 4'h0;
    endcase
  endfunction

endpackage

// File: logic/mbr_mem.sv
`timescale 1ns/100ps

module mbr_mem
  import mbr_pkg::*;
#(
  parameter int unsigned W     = 32,
  parameter int unsigned DEPTH = 31,
  parameter int unsigned AW    = 5
)
(
  input  wire logic          i_clk,
  input  wire logic          i_reset_n,
  input  wire logic          i_wa_en,
  input  wire logic [AW-1:0] i_wa_addr,
  input  wire logic [W-1:0]  i_wa_data,
  input  wire logic          i_wb_en,
  input  wire logic [AW-1:0] i_wb_addr,
  input  wire logic [W-1:0]  i_wb_data,
  input  wire logic [AW-1:0] i_ra_addr,
  input  wire logic [AW-1:0] i_rb_addr,
  output logic      [W-1:0]  o_ra_data,
  output logic      [W-1:0]  o_rb_data
);

  logic [W-1:0] mem_q [DEPTH];
  logic [W-1:0] mem_d [DEPTH];
  logic [W-1:0] ra_d;
  logic [W-1:0] rb_d;

  // ------------------------------------------------------------------
  // Storage; port b wins when both ports hit one entry.
  // ------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_entry
      always_comb
      begin
        mem_d[g] = mem_q[g];
        if (i_wa_en && i_wa_addr == AW'(g))
          mem_d[g] = i_wa_data;
        if (i_wb_en && i_wb_addr == AW'(g))
          mem_d[g] = i_wb_data;
      end

      always_ff @(posedge i_clk)
      begin
        mem_q[g] <= mem_d[g];
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // Registered read ports.
  // ------------------------------------------------------------------
  always_comb
  begin
    ra_d = (32'(i_ra_addr) < DEPTH) ? mem_q[i_ra_addr] : '0;
    rb_d = (32'(i_rb_addr) < DEPTH) ? mem_q[i_rb_addr] : '0;
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_ra_data <= '0;
      o_rb_data <= '0;
    end
    else
    begin
      o_ra_data <= ra_d;
      o_rb_data <= rb_d;
    end
  end

endmodule // mbr_mem

// File: logic/mbr_regfile.sv
`timescale 1ns/100ps

module mbr_regfile
  import mbr_pkg::*;
(
  input  wire logic                    i_clk,
  input  wire logic                    i_reset_n,
  input  wire mbr_pkg::mbr_rd_req_t    i_rd_a,
  input  wire mbr_pkg::mbr_rd_req_t    i_rd_b,
  input  wire mbr_pkg::mbr_wr_req_t    i_wr,
  input  wire logic                    i_call_en,
  input  wire logic [31:0]             i_call_ret_addr,
  input  wire mbr_pkg::mbr_exc_req_t   i_exc,
  input  wire logic                    i_restore,
  input  wire mbr_pkg::mbr_status_wr_t i_status_wr,
  output logic      [31:0]             o_rd_a_data,
  output logic      [31:0]             o_rd_b_data,
  output logic      [31:0]             o_status,
  output logic      [31:0]             o_saved_status,
  output logic                         o_privileged
);
  import mbr_pkg::*;

  logic [4:0]  mode;
  logic [31:0] saved_q [SAVED_CNT];
  logic [31:0] saved_d [SAVED_CNT];
  logic [31:0] status_d;
  logic [31:0] saved_out_d;
  logic [3:0]  cur_sel;
  logic [3:0]  exc_sel;
  logic [3:0]  nxt_sel;
  logic        wb_en;
  logic [4:0]  wb_addr;
  logic [31:0] wb_data;

  assign mode    = o_status[MODE_LSB +: 5];
  assign cur_sel = mbr_saved_sel(mode);
  assign exc_sel = mbr_saved_sel(i_exc.mode);

  // ------------------------------------------------------------------
  // Physical storage and mapped ports.
  // ------------------------------------------------------------------
  // Link writes use port b: the exception's new mode, else the current.
  always_comb
  begin
    wb_en   = i_exc.en || i_call_en;
    wb_addr = i_exc.en ? mbr_phys(i_exc.mode, IDX_LINK) : mbr_phys(mode, IDX_LINK);
    wb_data = i_exc.en ? i_exc.ret_addr : i_call_ret_addr;
  end

  mbr_mem #(
    .W     (DATA_W),
    .DEPTH (PHYS_REGS),
    .AW    (PHYS_W)
  ) u_mem (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_wa_en   (i_wr.en),
    .i_wa_addr (mbr_phys(mode, i_wr.idx)),
    .i_wa_data (i_wr.data),
    .i_wb_en   (wb_en),
    .i_wb_addr (wb_addr),
    .i_wb_data (wb_data),
    .i_ra_addr (mbr_phys(mode, i_rd_a.idx)),
    .i_rb_addr (mbr_phys(mode, i_rd_b.idx)),
    .o_ra_data (o_rd_a_data),
    .o_rb_data (o_rd_b_data)
  );

  // ------------------------------------------------------------------
  // Status and saved status words.
  // ------------------------------------------------------------------
  // Priority: exception entry, then return, then software write.
  always_comb
  begin
    status_d = o_status;
    for (int i = 0; i < SAVED_CNT; i++)
      saved_d[i] = saved_q[i];
    if (i_exc.en && exc_sel[3])
    begin
      saved_d[exc_sel[2:0]] = o_status;
      status_d = {o_status[31:5], i_exc.mode};
    end
    else if (i_restore && cur_sel[3])
      status_d = saved_q[cur_sel[2:0]];
    else if (i_status_wr.en)
    begin
      // User mode may only change the condition flags.
      if (mode == MODE_USER)
        status_d = {i_status_wr.data[31:FLAGS_LSB], o_status[FLAGS_LSB-1:0]};
      else
        status_d = i_status_wr.data;
    end
    nxt_sel     = mbr_saved_sel(status_d[MODE_LSB +: 5]);
    saved_out_d = nxt_sel[3] ? saved_d[nxt_sel[2:0]] : '0;
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_status       <= STATUS_RESET;
      o_saved_status <= '0;
      o_privileged   <= 1'b1;
      for (int i = 0; i < SAVED_CNT; i++)
        saved_q[i] <= '0;
    end
    else
    begin
      o_status       <= status_d;
      o_saved_status <= saved_out_d;
      o_privileged   <= status_d[MODE_LSB +: 5] != MODE_USER;
      for (int i = 0; i < SAVED_CNT; i++)
        saved_q[i] <= saved_d[i];
    end
  end

  // ------------------------------------------------------------------
  // Checks.
  // ------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  sequence low_write_s;
    i_wr.en && i_wr.idx <= IDX_LAST_SHARED && !i_call_en && !i_exc.en;
  endsequence

  sequence low_read_s;
    i_rd_a.en && i_rd_a.idx == $past(i_wr.idx) && !i_wr.en && !wb_en;
  endsequence

  sequence exc_enter_s;
    i_exc.en && exc_sel[3];
  endsequence

  sequence link_read_s;
    i_rd_b.en && i_rd_b.idx == IDX_LINK && !i_wr.en && !wb_en;
  endsequence

  sequence call_s;
    i_call_en && !i_exc.en && !i_restore && !i_status_wr.en;
  endsequence

  sequence user_write_s;
    mode == MODE_USER && i_status_wr.en && !i_exc.en;
  endsequence

  sequence foreign_exc_s;
    i_exc.en && !exc_sel[3] && !i_restore && !i_status_wr.en;
  endsequence

  exc_mode_a: assert property (exc_enter_s |=> mode == $past(i_exc.mode))
    else $error("exception entry did not switch mode");

  saved_capture_a: assert property (exc_enter_s |=> o_saved_status == $past(o_status))
    else $error("saved status did not capture the status word");

  restore_word_a: assert property (
    !i_exc.en && i_restore && cur_sel[3] |=> o_status == $past(o_saved_status))
    else $error("return did not restore the status word");

  shared_read_a: assert property (low_write_s ##1 low_read_s |=>
    o_rd_a_data == $past(i_wr.data, 2))
    else $error("shared register read back wrong data");

  exc_link_a: assert property (exc_enter_s ##1 link_read_s |=>
    o_rd_b_data == $past(i_exc.ret_addr, 2))
    else $error("link register lacks exception return address");

  fast_bank_a: assert property (
    mode == MODE_FAST && i_wr.idx >= IDX_FIRST_BANK && i_wr.idx <= IDX_LAST_FAST |->
    mbr_phys(mode, i_wr.idx) >= PHYS_FAST_BASE && mbr_phys(mode, i_wr.idx) < PHYS_FAST_SP)
    else $error("fast mode mapped to a shared register");

  system_user_a: assert property (
    mode == MODE_SYST |-> mbr_phys(mode, i_rd_a.idx) == mbr_phys(MODE_USER, i_rd_a.idx))
    else $error("system mode left the user bank");

  priv_flag_a: assert property (o_privileged == (mode != MODE_USER))
    else $error("privilege flag disagrees with mode");

  phys_range_a: assert property (mbr_phys(mode, i_rd_b.idx) < 5'(PHYS_REGS))
    else $error("mapped index beyond the physical file");

  call_link_a: assert property (call_s ##1 (i_rd_a.idx == IDX_LINK) |=>
    o_rd_a_data == $past(i_call_ret_addr, 2))
    else $error("link register lacks the call return address");

  user_flags_a: assert property (user_write_s |=>
    o_status[FLAGS_LSB-1:0] == $past(o_status[FLAGS_LSB-1:0]))
    else $error("user mode status write changed more than the flags");

  foreign_exc_a: assert property (foreign_exc_s |=> mode == $past(mode))
    else $error("non-exception mode code changed the mode");

  saved_none_a: assert property (
    mode == MODE_USER || mode == MODE_SYST |-> o_saved_status == '0)
    else $error("user or system mode shows a saved status word");

  shared_map_a: assert property (i_rd_a.idx <= IDX_LAST_SHARED |->
    mbr_phys(mode, i_rd_a.idx) == {1'b0, i_rd_a.idx})
    else $error("shared index mapped to a banked register");

  pc_map_a: assert property (mbr_phys(mode, IDX_PROG_CNT) == {1'b0, IDX_PROG_CNT})
    else $error("program counter index left the shared slot");

endmodule // mbr_regfile

// File: tb/mbr_pipe_model.sv
`timescale 1ns/100ps

module mbr_pipe_model
  import mbr_pkg::*;
(
  input  wire logic          i_clk,
  input  wire logic [3:0]    i_idx,
  output mbr_pkg::mbr_rd_req_t o_rd
);
  // ------------------------------------------------------------------
  // Second operand fetch
  // ------------------------------------------------------------------
  // The decode stage presents the second operand index one stage after
  // the bench selects it, so port B trails pm_idx by one clock.
  always @(posedge i_clk)
  begin
    o_rd <= '{en: 1'b1, idx: i_idx};
  end
endmodule // mbr_pipe_model

// File: tb/mode_banked_register_file_tb.sv
`timescale 1ns/100ps
`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("FAIL t=%0t got %h want %h", $time, got, exp); \
    end \
  end

module mode_banked_register_file_tb;
  import mbr_pkg::*;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic            i_clk, i_reset_n, i_call_en, i_restore, o_privileged;
  logic [31:0]     i_call_ret_addr, o_rd_a_data, o_rd_b_data, o_status, o_saved_status;
  mbr_rd_req_t     i_rd_a, rd_b;
  mbr_wr_req_t     i_wr;
  mbr_exc_req_t    i_exc;
  mbr_status_wr_t  i_status_wr;
  logic [3:0]      pm_idx;
  logic [4:0]      cur;
  logic [31:0]     old;
  logic [31:0]     expv [0:127];
  logic [4:0]      modes [7] = '{MODE_SUPV, MODE_FAST, MODE_NIRQ, MODE_ABRT,
                                 MODE_UNDF, MODE_SYST, MODE_USER};
  int              mismatches, samples_checked, cycles;

  mbr_regfile DUT (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_rd_a(i_rd_a), .i_rd_b(rd_b),
    .i_wr(i_wr), .i_call_en(i_call_en), .i_call_ret_addr(i_call_ret_addr), .i_exc(i_exc),
    .i_restore(i_restore), .i_status_wr(i_status_wr), .o_rd_a_data(o_rd_a_data),
    .o_rd_b_data(o_rd_b_data), .o_status(o_status), .o_saved_status(o_saved_status),
    .o_privileged(o_privileged));

  mbr_pipe_model PIPE (.i_clk(i_clk), .i_idx(pm_idx), .o_rd(rd_b));

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Slot in the expectation table: sixteen entries per bank, bank 0 is user.
  function automatic int slot(logic [4:0] m, logic [3:0] idx);
    int b;
    b = 0;
    if (m == MODE_FAST && idx >= 4'h8 && idx <= 4'hc)
      b = 1;
    else if (idx == 4'hd || idx == 4'he)
      case (m)
        MODE_FAST: b = 1;
        MODE_NIRQ: b = 2;
        MODE_SUPV: b = 3;
        MODE_ABRT: b = 4;
        MODE_UNDF: b = 5;
        default:   b = 0;
      endcase
    return b * 16 + int'(idx);
  endfunction

  task automatic close_out;
    if (mismatches == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic wr(logic [3:0] idx, logic [31:0] d);
    @(posedge i_clk);
    i_wr <= '{en: 1'b1, idx: idx, data: d};
    @(posedge i_clk);
    i_wr <= '0;
    expv[slot(cur, idx)] = d;
  endtask

  task automatic rd_chk(logic [3:0] idx);
    @(posedge i_clk);
    i_rd_a <= '{en: 1'b1, idx: idx};
    @(posedge i_clk);
    @(negedge i_clk);
    `CHK(o_rd_a_data, expv[slot(cur, idx)])
  endtask

  // User mode can only be left through an exception entry.
  task automatic go_mode(logic [4:0] m);
    @(posedge i_clk);
    if (cur == MODE_USER)
      i_exc <= '{en: 1'b1, mode: m, ret_addr: 32'h0};
    else
      i_status_wr <= '{en: 1'b1, data: {24'h0, 3'b110, m}};
    @(posedge i_clk);
    if (cur == MODE_USER)
      expv[slot(m, 4'he)] = 32'h0;
    i_exc <= '0;
    i_status_wr <= '0;
    cur = m;
    @(negedge i_clk);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_banks;
    foreach (modes[i])
    begin
      go_mode(modes[i]);
      for (int k = 0; k < 16; k++)
        wr(k[3:0], {i[7:0], k[7:0], 16'ha5c3});
    end
    foreach (modes[i])
    begin
      go_mode(modes[i]);
      for (int k = 0; k < 16; k++)
        rd_chk(k[3:0]);
    end
  endtask

  task automatic t_exc;
    go_mode(MODE_SUPV);
    go_mode(MODE_SYST);
    old = o_status;
    @(posedge i_clk);
    i_exc <= '{en: 1'b1, mode: MODE_NIRQ, ret_addr: 32'h1234_5670};
    pm_idx <= 4'he;
    @(posedge i_clk);
    i_exc <= '0;
    @(negedge i_clk);
    `CHK(o_status[4:0], MODE_NIRQ)
    `CHK(o_saved_status, old)
    `CHK(o_privileged, 1'b1)
    cur = MODE_NIRQ;
    expv[slot(cur, 4'he)] = 32'h1234_5670;
    rd_chk(4'he);
    `CHK(o_rd_b_data, 32'h1234_5670)
    @(posedge i_clk);
    i_call_en <= 1'b1;
    i_call_ret_addr <= 32'h0000_0abc;
    @(posedge i_clk);
    i_call_en <= 1'b0;
    expv[slot(cur, 4'he)] = 32'h0000_0abc;
    rd_chk(4'he);
    @(posedge i_clk);
    i_restore <= 1'b1;
    @(posedge i_clk);
    i_restore <= 1'b0;
    @(negedge i_clk);
    `CHK(o_status, old)
    `CHK(o_saved_status, 32'h0)
    cur = MODE_SYST;
    rd_chk(4'he);
  endtask

  task automatic t_user;
    go_mode(MODE_USER);
    old = o_status;
    `CHK(o_privileged, 1'b0)
    @(posedge i_clk);
    i_status_wr <= '{en: 1'b1, data: 32'hffff_ffff};
    i_restore <= 1'b1;
    @(posedge i_clk);
    i_status_wr <= '0;
    i_restore <= 1'b0;
    @(negedge i_clk);
    `CHK(o_status, {4'hf, old[27:0]})
  endtask

  task automatic t_dual;
    @(posedge i_clk);
    pm_idx <= 4'hd;
    @(posedge i_clk);
    i_rd_a <= '{en: 1'b1, idx: 4'h3};
    @(posedge i_clk);
    @(negedge i_clk);
    `CHK(o_rd_a_data, expv[slot(cur, 4'h3)])
    `CHK(o_rd_b_data, expv[slot(cur, 4'hd)])
  endtask

  // Back-to-back write and read, a link write racing a port write, and an
  // exception request that names a mode without its own bank.
  task automatic t_race;
    @(posedge i_clk);
    i_wr <= '{en: 1'b1, idx: 4'h3, data: 32'h3c3c_0003};
    @(posedge i_clk);
    i_wr <= '0;
    i_rd_a <= '{en: 1'b1, idx: 4'h3};
    @(posedge i_clk);
    @(negedge i_clk);
    `CHK(o_rd_a_data, 32'h3c3c_0003)
    expv[slot(cur, 4'h3)] = 32'h3c3c_0003;
    @(posedge i_clk);
    i_wr <= '{en: 1'b1, idx: 4'he, data: 32'h0bad_0bad};
    i_call_en <= 1'b1;
    i_call_ret_addr <= 32'h0000_0c40;
    @(posedge i_clk);
    i_wr <= '0;
    i_call_en <= 1'b0;
    i_rd_a <= '{en: 1'b1, idx: 4'he};
    @(posedge i_clk);
    @(negedge i_clk);
    `CHK(o_rd_a_data, 32'h0000_0c40)
    expv[slot(cur, 4'he)] = 32'h0000_0c40;
    @(posedge i_clk);
    i_exc <= '{en: 1'b1, mode: MODE_SYST, ret_addr: 32'h0000_5a50};
    @(posedge i_clk);
    i_exc <= '0;
    @(negedge i_clk);
    `CHK(o_status[4:0], MODE_USER)
    `CHK(o_privileged, 1'b0)
    `CHK(o_saved_status, 32'h0)
    expv[slot(MODE_SYST, 4'he)] = 32'h0000_5a50;
    rd_chk(4'he);
  endtask

  // ------------------------------------------------------------------
  // Clock, timeout and main sequence
  // ------------------------------------------------------------------
  initial
  begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      close_out();
    end
  end

  initial
  begin
    i_reset_n = 1'b0;
    i_rd_a = '0;
    i_wr = '0;
    i_call_en = 1'b0;
    i_call_ret_addr = 32'h0;
    i_exc = '0;
    i_restore = 1'b0;
    i_status_wr = '0;
    pm_idx = 4'h0;
    cur = MODE_SUPV;
    repeat (8) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(negedge i_clk);
    `CHK(o_status, STATUS_RESET)
    `CHK(o_privileged, 1'b1)
    `CHK(o_saved_status, 32'h0)
    t_banks();
    t_exc();
    t_user();
    t_dual();
    t_race();
    close_out();
  end
endmodule // mode_banked_register_file_tb
